//--- src/maf_pkg.sv
// Package for the station address, group hash and PHY management block.
// Assumes a 32-bit AHB-Lite register bus and one MAC clock domain.
package maf_pkg;
  // Register byte offsets.
  localparam logic [11:0] ADDR_STA_HIGH  = 12'h0104;
  localparam logic [11:0] ADDR_STA_LOW   = 12'h0108;
  localparam logic [11:0] ADDR_HASH_HIGH = 12'h010c;
  localparam logic [11:0] ADDR_HASH_LOW  = 12'h0110;
  localparam logic [11:0] ADDR_PHY_CTRL  = 12'h0114;
  localparam logic [11:0] ADDR_PHY_VALUE = 12'h0118;
  localparam logic [11:0] ADDR_FILT_CTRL = 12'h0100;
  // Reset values.
  localparam logic [15:0] RST_STA_HIGH   = 16'hffff;
  localparam logic [31:0] RST_STA_LOW    = 32'hffff_ffff;
  localparam logic [31:0] RST_HASH       = 32'h0000_0000;
  localparam logic [15:0] RST_PHY_VALUE  = 16'h0000;
  localparam logic [4:0]  RST_PHY_ADDR   = 5'h00;
  localparam logic [4:0]  RST_PHY_INDEX  = 5'h00;
  // Management control field positions.
  localparam int          PHY_ADDR_LSB   = 11;
  localparam int          PHY_INDEX_LSB  = 6;
  localparam int          PHY_WRITE_BIT  = 1;
  localparam int          PHY_BUSY_BIT   = 0;
  // Filter control field positions.
  localparam int          PASS_GROUP_BIT = 0;
  localparam int          PROTECT_BIT    = 1;
  // PHY access cycle count, not used; the PHY model's access time is set by its delay_i input.
  localparam int          PHY_ACCESS_CYC = 4;
  // AHB transfer type.
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  // Management engine states.
  typedef enum logic [1:0] {
    MAF_IDLE = 2'b00,
    MAF_BUSY = 2'b01,
    MAF_DONE = 2'b11
  } maf_mgmt_state_t;
endpackage

//--- src/maf_hash_check.sv
// Group address filter: hash lookup and station address match for one destination address.
// Assumes the receive path presents a stable address and hash index with a strobe.
`timescale 1ns/1ps
module maf_hash_check (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Frame address.
  input  wire logic        chk_valid_i,
  input  wire logic [47:0] dest_addr_i,
  input  wire logic [5:0]  hash_index_i,
  // Settings.
  input  wire logic [31:0] hash_high_i,
  input  wire logic [31:0] hash_low_i,
  input  wire logic [47:0] station_addr_i,
  input  wire logic        pass_all_group_frames_i,
  // Verdict.
  output logic             verdict_valid_o,
  output logic             accept_o,
  output logic             station_match_o
);
  // Bit 0 of the first received octet marks a group address.
  wire       is_group   = dest_addr_i[0];
  // Top index bit picks the word, the rest pick the bit.
  wire       hash_bit   = hash_index_i[5] ? hash_high_i[hash_index_i[4:0]]
                                          : hash_low_i[hash_index_i[4:0]];
  wire       group_ok   = pass_all_group_frames_i | hash_bit;
  // Station address octets compare in reception order, octet n at bits 8n+7:8n.
  wire [5:0] octet_eq;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_oct
      assign octet_eq[g] = dest_addr_i[8*g +: 8] == station_addr_i[8*g +: 8];
    end
  endgenerate
  wire       sta_hit    = &octet_eq;
  wire       nxt_accept = is_group ? group_ok : sta_hit;

  // Registers the verdict one cycle after the strobe.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      verdict_valid_o <= 1'b0;
      accept_o        <= 1'b0;
      station_match_o <= 1'b0;
    end else begin
      verdict_valid_o <= chk_valid_i;
      accept_o        <= chk_valid_i & nxt_accept;
      station_match_o <= chk_valid_i & sta_hit;
    end
  end

  property p_group_accept;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (chk_valid_i && is_group) |=> (accept_o == $past(group_ok));
  endproperty
  a_group_accept: assert property (p_group_accept) else $error("Group verdict wrong.");

  property p_pass_all;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (chk_valid_i && is_group && pass_all_group_frames_i) |=> accept_o;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("Pass-all frame rejected.");

  property p_index_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (chk_valid_i && is_group && !pass_all_group_frames_i && hash_index_i == 6'h00)
        |=> (accept_o == $past(hash_low_i[0]));
  endproperty
  a_index_zero: assert property (p_index_zero) else $error("Index zero not low bit zero.");
endmodule

//--- src/maf_mgmt_engine.sv
// PHY management access engine: runs one register read or write on the PHY port.
// Assumes the PHY port answers with a done pulse within a bounded time.
`timescale 1ns/1ps
module maf_mgmt_engine (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Start and completion.
  input  wire logic        start_i,
  output logic             busy_o,
  output logic             done_o,
  // PHY register port.
  output logic             phy_req_o,
  input  wire logic        phy_ack_i
);
  maf_pkg::maf_mgmt_state_t state_ff, nxt_state;

  // Next state: idle, wait for acknowledge, one cycle done.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      maf_pkg::MAF_IDLE: if (start_i) nxt_state = maf_pkg::MAF_BUSY;
      maf_pkg::MAF_BUSY: if (phy_ack_i) nxt_state = maf_pkg::MAF_DONE;
      maf_pkg::MAF_DONE: nxt_state = maf_pkg::MAF_IDLE;
      default:           nxt_state = maf_pkg::MAF_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) state_ff <= maf_pkg::MAF_IDLE;
    else          state_ff <= nxt_state;
  end

  assign busy_o    = state_ff == maf_pkg::MAF_BUSY;
  assign phy_req_o = busy_o;
  assign done_o    = state_ff == maf_pkg::MAF_DONE;

  property p_done_after_ack;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (busy_o && phy_ack_i) |=> done_o ##1 !busy_o;
  endproperty
  a_done_after_ack: assert property (p_done_after_ack) else $error("Access did not finish.");
endmodule

//--- src/maf_top.sv
// Station address, group hash table and PHY management registers on AHB-Lite.
// Assumes one MAC clock, an internal PHY register port with a request and acknowledge,
// and a receive path that strobes each destination address with its hash index.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module maf_top (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Receive path address check.
  input  wire logic        chk_valid_i,
  input  wire logic [47:0] dest_addr_i,
  input  wire logic [5:0]  hash_index_i,
  output logic             verdict_valid_o,
  output logic             accept_o,
  output logic             station_match_o,
  // Internal PHY register port.
  output logic             phy_req_o,
  output logic             phy_write_o,
  output logic      [4:0]  phy_addr_o,
  output logic      [4:0]  phy_reg_index_o,
  output logic      [15:0] phy_wdata_o,
  input  wire logic        phy_ack_i,
  input  wire logic [15:0] phy_rdata_i
);
  // Address phase capture.
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  // Registers.
  logic [15:0] station_address_high_ff;
  logic [31:0] station_address_low_ff;
  logic [31:0] group_hash_high_ff;
  logic [31:0] group_hash_low_ff;
  logic [4:0]  phy_addr_ff;
  logic [4:0]  phy_reg_index_ff;
  logic        phy_write_select_ff;
  logic [15:0] phy_value_ff;
  logic        pass_all_group_frames_ff;
  logic        protect_ff;
  logic        protect_valid_ff = 1'b0; // Power-up value; no reset reaches this flip-flop.
  logic        phy_req_ff;
  // Engine wires.
  logic        eng_busy;
  logic        eng_done;
  logic        eng_req;

  // Address decode for the address phase and the pending write.
  wire         addr_ph    = hsel_i & hready_i & htrans_i[1];
  wire [11:0]  a_off      = haddr_i[11:0];
  wire         wr_now     = wr_pend_ff;
  wire         wr_sta_h   = wr_now && wr_addr_ff == maf_pkg::ADDR_STA_HIGH;
  wire         wr_sta_l   = wr_now && wr_addr_ff == maf_pkg::ADDR_STA_LOW;
  wire         wr_hash_h  = wr_now && wr_addr_ff == maf_pkg::ADDR_HASH_HIGH;
  wire         wr_hash_l  = wr_now && wr_addr_ff == maf_pkg::ADDR_HASH_LOW;
  wire         wr_ctrl    = wr_now && wr_addr_ff == maf_pkg::ADDR_PHY_CTRL;
  wire         wr_value   = wr_now && wr_addr_ff == maf_pkg::ADDR_PHY_VALUE;
  wire         wr_filt    = wr_now && wr_addr_ff == maf_pkg::ADDR_FILT_CTRL;
  // Control and data writes are ignored while an access runs.
  wire         mgmt_open  = ~eng_busy;
  wire         start_acc  = wr_ctrl & mgmt_open & hwdata_i[maf_pkg::PHY_BUSY_BIT];

  // Read image of the control register, busy bit from the engine.
  wire [31:0]  ctrl_img   = {16'h0000, phy_addr_ff, phy_reg_index_ff, 4'h0, phy_write_select_ff, eng_busy};

  // Read data multiplexer, unmapped addresses read zero.
  wire [31:0]  rd_mux     =
    (a_off == maf_pkg::ADDR_STA_HIGH)  ? {16'h0000, station_address_high_ff} :
    (a_off == maf_pkg::ADDR_STA_LOW)   ? station_address_low_ff :
    (a_off == maf_pkg::ADDR_HASH_HIGH) ? group_hash_high_ff :
    (a_off == maf_pkg::ADDR_HASH_LOW)  ? group_hash_low_ff :
    (a_off == maf_pkg::ADDR_PHY_CTRL)  ? ctrl_img :
    (a_off == maf_pkg::ADDR_PHY_VALUE) ? {16'h0000, phy_value_ff} :
    (a_off == maf_pkg::ADDR_FILT_CTRL) ? {30'h0000_0000, protect_ff, pass_all_group_frames_ff} :
                                         32'h0000_0000;

  // Bus phase tracking; the slave is always ready with an OKAY answer.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_ph & hwrite_i;
      if (addr_ph) wr_addr_ff <= a_off;
      if (addr_ph && !hwrite_i) rdata_ff <= rd_mux;
    end
  end

  assign hrdata_o    = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Ordinary registers, loaded with their reset values by every reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      station_address_high_ff  <= maf_pkg::RST_STA_HIGH;
      group_hash_high_ff       <= maf_pkg::RST_HASH;
      group_hash_low_ff        <= maf_pkg::RST_HASH;
      pass_all_group_frames_ff <= 1'b0;
    end else begin
      if (wr_sta_h)  station_address_high_ff <= hwdata_i[15:0];
      if (wr_hash_h) group_hash_high_ff      <= hwdata_i;
      if (wr_hash_l) group_hash_low_ff       <= hwdata_i;
      if (wr_filt)   pass_all_group_frames_ff <= hwdata_i[maf_pkg::PASS_GROUP_BIT];
    end
  end

  // Protected lower address: its flip-flops have no reset and load the reset
  // value on reset only while protection is not armed.
  always_ff @(posedge clk_sys_i) begin
    if (!protect_valid_ff || !protect_ff) begin
      if (!rst_n_i) station_address_low_ff <= maf_pkg::RST_STA_LOW;
      else if (wr_sta_l) station_address_low_ff <= hwdata_i;
      else if (!protect_valid_ff) station_address_low_ff <= maf_pkg::RST_STA_LOW;
    end else if (rst_n_i && wr_sta_l) begin
      station_address_low_ff <= hwdata_i;
    end
  end

  // Protection enable, itself kept across resets once armed.
  always_ff @(posedge clk_sys_i) begin
    if (!protect_valid_ff) begin
      protect_valid_ff <= 1'b1;
      protect_ff       <= 1'b0;
    end else if (rst_n_i && wr_filt) begin
      protect_ff       <= hwdata_i[maf_pkg::PROTECT_BIT];
    end
  end

  // Management control and data registers.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_addr_ff         <= maf_pkg::RST_PHY_ADDR;
      phy_reg_index_ff    <= maf_pkg::RST_PHY_INDEX;
      phy_write_select_ff <= 1'b0;
      phy_value_ff        <= maf_pkg::RST_PHY_VALUE;
    end else begin
      if (wr_ctrl && mgmt_open) begin
        phy_addr_ff         <= hwdata_i[maf_pkg::PHY_ADDR_LSB +: 5];
        phy_reg_index_ff    <= hwdata_i[maf_pkg::PHY_INDEX_LSB +: 5];
        phy_write_select_ff <= hwdata_i[maf_pkg::PHY_WRITE_BIT];
      end
      if (wr_value && mgmt_open) phy_value_ff <= hwdata_i[15:0];
      else if (eng_busy && phy_ack_i && !phy_write_select_ff) phy_value_ff <= phy_rdata_i;
    end
  end

  // PHY port outputs, all from flip-flops.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_req_ff <= 1'b0;
    end else begin
      phy_req_ff <= eng_req & ~phy_ack_i;
    end
  end

  assign phy_req_o       = phy_req_ff;
  assign phy_write_o     = phy_write_select_ff;
  assign phy_addr_o      = phy_addr_ff;
  assign phy_reg_index_o = phy_reg_index_ff;
  assign phy_wdata_o     = phy_value_ff;

  // Access sequencing.
  maf_mgmt_engine u_engine (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start_acc),
    .busy_o    (eng_busy),
    .done_o    (eng_done),
    .phy_req_o (eng_req),
    .phy_ack_i (phy_ack_i)
  );

  // Receive address filter.
  maf_hash_check u_check (
    .clk_sys_i               (clk_sys_i),
    .rst_n_i                 (rst_n_i),
    .chk_valid_i             (chk_valid_i),
    .dest_addr_i             (dest_addr_i),
    .hash_index_i            (hash_index_i),
    .hash_high_i             (group_hash_high_ff),
    .hash_low_i              (group_hash_low_ff),
    .station_addr_i          ({station_address_high_ff, station_address_low_ff}),
    .pass_all_group_frames_i (pass_all_group_frames_ff),
    .verdict_valid_o         (verdict_valid_o),
    .accept_o                (accept_o),
    .station_match_o         (station_match_o)
  );

  // Checks on the register side.
  property p_busy_starts;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      start_acc |=> eng_busy;
  endproperty
  a_busy_starts: assert property (p_busy_starts) else $error("Busy not set on start.");

  property p_value_held;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (eng_busy && phy_write_select_ff) |=> $stable(phy_value_ff) || !$past(eng_busy);
  endproperty
  a_value_held: assert property (p_value_held) else $error("Write data changed during access.");

  property p_read_lands;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (eng_busy && phy_ack_i && !phy_write_select_ff) |=> phy_value_ff == $past(phy_rdata_i);
  endproperty
  a_read_lands: assert property (p_read_lands) else $error("Read result not stored.");

  property p_hash_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_hash_h |=> group_hash_high_ff == $past(hwdata_i);
  endproperty
  a_hash_write: assert property (p_hash_write) else $error("Hash high write lost.");

  property p_high_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (addr_ph && !hwrite_i && a_off == maf_pkg::ADDR_STA_HIGH) |=> hrdata_o[31:16] == 16'h0000;
  endproperty
  a_high_reserved: assert property (p_high_reserved) else $error("Reserved bits nonzero.");

  property p_index_out;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_ctrl && mgmt_open) |=> phy_reg_index_o == $past(hwdata_i[10:6]);
  endproperty
  a_index_out: assert property (p_index_out) else $error("Register index not taken.");

  property p_sta_high_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_sta_h |=> station_address_high_ff == $past(hwdata_i[15:0]);
  endproperty
  a_sta_high_write: assert property (p_sta_high_write) else $error("Station high write lost.");

  property p_sta_low_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_sta_l |=> station_address_low_ff == $past(hwdata_i);
  endproperty
  a_sta_low_write: assert property (p_sta_low_write) else $error("Station low write lost.");

  property p_low_reset;
    @(posedge clk_sys_i)
      (protect_valid_ff && !protect_ff && !rst_n_i) |=> station_address_low_ff == maf_pkg::RST_STA_LOW;
  endproperty
  a_low_reset: assert property (p_low_reset) else $error("Station low not reset.");

  property p_protect_hold;
    @(posedge clk_sys_i)
      (protect_valid_ff && protect_ff && !rst_n_i) |=> $stable(station_address_low_ff);
  endproperty
  a_protect_hold: assert property (p_protect_hold) else $error("Protected address lost in reset.");

  property p_hash_low_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_hash_l |=> group_hash_low_ff == $past(hwdata_i);
  endproperty
  a_hash_low_write: assert property (p_hash_low_write) else $error("Hash low write lost.");

  property p_busy_reads;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (addr_ph && !hwrite_i && a_off == maf_pkg::ADDR_PHY_CTRL) |=> hrdata_o[0] == $past(eng_busy);
  endproperty
  a_busy_reads: assert property (p_busy_reads) else $error("Busy bit read wrong.");

  // Request follows one cycle after busy.
  sequence s_req_raised;
    eng_busy ##1 phy_req_o;
  endsequence

  property p_req_follows;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      start_acc |=> s_req_raised;
  endproperty
  a_req_follows: assert property (p_req_follows) else $error("Request did not follow start.");

  property p_done_clears;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      eng_done |-> !eng_busy && !phy_req_o;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("Busy held after done.");

  property p_value_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (addr_ph && !hwrite_i && a_off == maf_pkg::ADDR_PHY_VALUE) |=> hrdata_o[31:16] == 16'h0000;
  endproperty
  a_value_reserved: assert property (p_value_reserved) else $error("Data reserved bits nonzero.");
endmodule

//--- testbench/maf_phy_model.sv
// Model of the internal PHY management registers, answering after a set delay.
// Assumes the block holds its request and fields until it samples the acknowledge.
`timescale 1ns/1ps
module maf_phy_model (
  // Clock, reset and answer delay.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  delay_i,
  // Management port.
  input  wire logic        phy_req_i,
  input  wire logic        phy_write_i,
  input  wire logic [4:0]  phy_reg_index_i,
  input  wire logic [15:0] phy_wdata_i,
  output logic             phy_ack_o,
  output logic      [15:0] phy_rdata_o
);
  logic [15:0] regs_ff [32];
  logic [3:0]  wait_ff;
  logic [15:0] rdata_ff;
  // Read data only holds with the acknowledge, so a late sample sees the inverse.
  assign phy_rdata_o = phy_ack_o ? rdata_ff : ~rdata_ff;
  // Waits the delay, then acknowledges once and performs the access.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= 16'h1000 | 16'(i);
      end
      wait_ff   <= 4'h0;
      rdata_ff  <= 16'h0000;
      phy_ack_o <= 1'b0;
    end else begin
      phy_ack_o <= 1'b0;
      if (phy_req_i && !phy_ack_o) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff == delay_i) begin
          wait_ff   <= 4'h0;
          phy_ack_o <= 1'b1;
          rdata_ff  <= regs_ff[phy_reg_index_i];
          if (phy_write_i) begin
            regs_ff[phy_reg_index_i] <= phy_wdata_i;
          end
        end
      end
    end
  end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the station address, hash filter and PHY management block.
// Assumes one AHB-Lite master, the PHY model on the management port, 100 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic        clk_sys;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        chk_valid;
  logic [47:0] dest_addr;
  logic [5:0]  hash_index;
  logic        verdict_valid;
  logic        accept;
  logic        station_match;
  logic        phy_req;
  logic        phy_write;
  logic        phy_ack;
  logic [4:0]  phy_addr;
  logic [4:0]  phy_reg_index;
  logic [15:0] phy_wdata;
  logic [15:0] phy_rdata;
  logic [3:0]  phy_delay;
  logic [26:0] seen_cmd;
  int          errors;
  int          check_count;
  int          cycles;
  localparam logic [31:0] A_HI = {20'h0_0000, maf_pkg::ADDR_STA_HIGH};
  localparam logic [31:0] A_LO = {20'h0_0000, maf_pkg::ADDR_STA_LOW};
  localparam logic [31:0] A_HH = {20'h0_0000, maf_pkg::ADDR_HASH_HIGH};
  localparam logic [31:0] A_HL = {20'h0_0000, maf_pkg::ADDR_HASH_LOW};
  localparam logic [31:0] A_PC = {20'h0_0000, maf_pkg::ADDR_PHY_CTRL};
  localparam logic [31:0] A_PV = {20'h0_0000, maf_pkg::ADDR_PHY_VALUE};
  localparam logic [31:0] A_FC = {20'h0_0000, maf_pkg::ADDR_FILT_CTRL};
  // Design under test; the slave's ready is the bus ready.
  maf_top maf_top_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .chk_valid_i(chk_valid), .dest_addr_i(dest_addr),
    .hash_index_i(hash_index), .verdict_valid_o(verdict_valid), .accept_o(accept),
    .station_match_o(station_match), .phy_req_o(phy_req), .phy_write_o(phy_write), .phy_addr_o(phy_addr),
    .phy_reg_index_o(phy_reg_index), .phy_wdata_o(phy_wdata), .phy_ack_i(phy_ack), .phy_rdata_i(phy_rdata));
  // PHY register set on the far side.
  maf_phy_model maf_phy_model_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .delay_i(phy_delay), .phy_req_i(phy_req),
    .phy_write_i(phy_write), .phy_reg_index_i(phy_reg_index), .phy_wdata_i(phy_wdata), .phy_ack_o(phy_ack),
    .phy_rdata_o(phy_rdata));
  // Clock generator.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Records the management fields at the acknowledge, when the access really happens.
  always @(posedge clk_sys) begin
    if (phy_ack && phy_req) begin
      seen_cmd <= {phy_write, phy_addr, phy_reg_index, phy_wdata};
    end
  end
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 5000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single-word transfer: address phase held until ready, then the data phase.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= maf_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(what, rd, exp);
    check("response", 32'(hresp), 32'h0000_0000);
  endtask
  // Strobes one destination address and judges the verdict one cycle later.
  task automatic filt(input logic [47:0] dest, input logic [5:0] idx, input logic acc, input logic match);
    @(posedge clk_sys);
    chk_valid  <= 1'b1;
    dest_addr  <= dest;
    hash_index <= idx;
    @(posedge clk_sys);
    chk_valid <= 1'b0;
    #1;
    check("verdict", 32'(verdict_valid), 32'h0000_0001);
    check("accept", 32'(accept), 32'(acc));
    check("station match", 32'(station_match), 32'(match));
  endtask
  // Runs one PHY access, polls busy and checks what reached the PHY and the data register.
  task automatic phy_op(input logic w, input logic [4:0] idx, input logic [15:0] wd, input logic [3:0] dly,
                        input logic [15:0] exp);
    logic [31:0] rd;
    int          n;
    phy_delay <= dly;
    if (w) begin
      wr(A_PV, {16'h0000, wd});
    end
    wr(A_PC, {16'h0000, 5'h01, idx, 4'h0, w, 1'b1});
    ahb(1'b0, A_PC, 32'h0000_0000, rd);
    check("busy after start", 32'(rd[0]), 32'h0000_0001);
    if (w) begin
      wr(A_PV, 32'h0000_ffff);
    end
    n = 0;
    do begin
      ahb(1'b0, A_PC, 32'h0000_0000, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    check("busy cleared", 32'(rd[0]), 32'h0000_0000);
    check("control readback", rd, {16'h0000, 5'h01, idx, 4'h0, w, 1'b0});
    check("phy command", 32'(seen_cmd[26:16]), 32'({w, 5'h01, idx}));
    if (w) begin
      check("phy write data", 32'(seen_cmd[15:0]), 32'(wd));
    end
    rdc("data register", A_PV, {16'h0000, exp});
  endtask
  task automatic test_reset_values();
    rdc("station high", A_HI, 32'h0000_ffff);
    rdc("station low", A_LO, 32'hffff_ffff);
    rdc("hash high", A_HH, 32'h0000_0000);
    rdc("hash low", A_HL, 32'h0000_0000);
    rdc("phy control", A_PC, 32'h0000_0000);
    rdc("phy value", A_PV, 32'h0000_0000);
    $display("test reset values done");
  endtask
  task automatic test_rw();
    wr(A_HI, 32'hffff_1234);
    rdc("station high", A_HI, 32'h0000_1234);
    wr(A_LO, 32'h5a5a_a5a5);
    rdc("station low", A_LO, 32'h5a5a_a5a5);
    wr(A_HH, 32'hdead_0001);
    rdc("hash high", A_HH, 32'hdead_0001);
    wr(A_HL, 32'h0bad_f00d);
    rdc("hash low", A_HL, 32'h0bad_f00d);
    wr(A_PV, 32'hffff_beef);
    rdc("phy value", A_PV, 32'h0000_beef);
    wr(32'h0000_0200, 32'h1234_5678);
    rdc("unmapped", 32'h0000_0200, 32'h0000_0000);
    $display("test register access done");
  endtask
  task automatic test_filter();
    wr(A_LO, 32'h7856_3412);
    wr(A_HI, 32'h0000_bc9a);
    filt(48'hbc9a_7856_3412, 6'h00, 1'b1, 1'b1);
    filt(48'h9abc_7856_3412, 6'h00, 1'b0, 1'b0);
    filt(48'hbc9a_7856_3214, 6'h00, 1'b0, 1'b0);
    wr(A_HL, 32'h0000_0001);
    wr(A_HH, 32'h8000_0000);
    filt(48'h0000_0000_0001, 6'h00, 1'b1, 1'b0);
    filt(48'h0000_0000_0001, 6'h3f, 1'b1, 1'b0);
    filt(48'h0000_0000_0001, 6'h20, 1'b0, 1'b0);
    filt(48'h0000_0000_0001, 6'h1f, 1'b0, 1'b0);
    wr(A_FC, 32'h0000_0001);
    filt(48'h0000_0000_0001, 6'h20, 1'b1, 1'b0);
    wr(A_FC, 32'h0000_0000);
    $display("test filter done");
  endtask
  task automatic test_phy();
    phy_op(1'b1, 5'h1f, 16'ha55a, 4'h6, 16'ha55a);
    phy_op(1'b0, 5'h1f, 16'h0000, 4'h0, 16'ha55a);
    phy_op(1'b0, 5'h03, 16'h0000, 4'h2, 16'h1003);
    $display("test phy access done");
  endtask
  task automatic test_protect();
    wr(A_FC, 32'h0000_0002);
    wr(A_LO, 32'h0102_0304);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc("protected low", A_LO, 32'h0102_0304);
    rdc("station high", A_HI, 32'h0000_ffff);
    $display("test reset protection done");
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    errors = 0;
    check_count = 0;
    cycles = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    chk_valid = 1'b0;
    dest_addr = 48'h0000_0000_0000;
    hash_index = 6'h00;
    phy_delay = 4'h0;
    seen_cmd = 27'h000_0000;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset_values();
    test_rw();
    test_filter();
    test_phy();
    test_protect();
    conclude();
  end
endmodule
